//--- src/oscsw_consts.svh
// Offsets, field positions, reset values and timing counts of the oscillator switch block.
`ifndef OSCSW_CONSTS_SVH
`define OSCSW_CONSTS_SVH
`define OSCSW_OFF_CTRL      12'h000
`define OSCSW_OFF_DIV       12'h004
`define OSCSW_OFF_TRIM      12'h008
`define OSCSW_OFF_STATUS    12'h00C
`define OSCSW_KEY_HI_A      8'h78
`define OSCSW_KEY_HI_B      8'h9A
`define OSCSW_KEY_LO_A      8'h46
`define OSCSW_KEY_LO_B      8'h57
`define OSCSW_BIT_FREEZE    7
`define OSCSW_BIT_PINFRZ    6
`define OSCSW_BIT_LOCK      5
`define OSCSW_BIT_FAIL      3
`define OSCSW_BIT_PKEEP     2
`define OSCSW_BIT_SECON     1
`define OSCSW_BIT_REQ       0
`define OSCSW_DIV_RESET     16'h0100
`define OSCSW_SETTLE_CYC    4'hA
`define OSCSW_STARTUP_CYC   16'h0400
`endif

//--- src/oscsw_pkg.sv
// Types shared by the oscillator switch block.
package oscsw_pkg;
  typedef enum logic [2:0] {
    SRC_FAST     = 3'h0,
    SRC_FAST_PLL = 3'h1,
    SRC_PRI      = 3'h2,
    SRC_PRI_PLL  = 3'h3,
    SRC_SEC      = 3'h4,
    SRC_SLOW_RC  = 3'h5,
    SRC_RSVD     = 3'h6,
    SRC_FAST_DIV = 3'h7
  } oscsw_src_t;
  // Gray coded along idle, check, start, settle.
  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_CHECK  = 2'b01,
    SW_START  = 2'b11,
    SW_SETTLE = 2'b10
  } oscsw_state_t;
endpackage : oscsw_pkg

//--- src/oscsw_ctrl.sv
// Oscillator switch control: APB registers and clock switch sequencer.
// What this block does
// RULE_01 - Freeze blocks switching when monitor enabled
// RULE_02 - Pin freeze needs unlock; one-shot sticks
// RULE_03 - Lock bit follows PLL, clears on switch
// RULE_04 - Fail flag set on monitor detected failure
// RULE_05 - Sleep keep bit keeps primary running
// RULE_06 - Secondary enable bit drives oscillator enable
// RULE_07 - Request starts switch, reads 0 when done
// RULE_08 - Interrupt clears ratio enable when restore set
// RULE_09 - Ratio field selects 1 to 2^n
// RULE_10 - Ratio disabled forces 1 to 1
// RULE_11 - Postscale field divides fast RC, resets 001
// RULE_12 - Six bit signed trim value adjusts RC
// RULE_13 - Switching enabled only with config 00; code enables it for 00 and 01
// RULE_14 - Switching disabled: power-on source, request held 0
// RULE_15 - High byte write needs 78h,9Ah keys
// RULE_16 - Low byte write needs 46h,57h keys
// RULE_17 - Equal sources make request redundant, abort
// RULE_18 - Valid switch clears lock and fail flag
// RULE_19 - Start new source, wait timer or lock
// RULE_20 - Wait ten cycles, switch, copy selection
// RULE_21 - Old source off except kept slow RC/secondary
// RULE_22 - Software avoids direct PLL to PLL switching
// RULE_23 - Three bit source code mapping
// RULE_24 - Unkeyed control writes are ignored
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
`include "oscsw_consts.svh"
module oscsw_ctrl #(
  parameter logic [15:0] STARTUP_CYCLES = `OSCSW_STARTUP_CYC
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  input  wire logic [1:0]           switch_monitor_cfg,
  input  wire oscsw_pkg::oscsw_src_t poweron_source_cfg,
  input  wire logic                 pin_lock_one_shot,
  input  wire logic                 wdt_enabled,
  input  wire logic                 pll_locked,
  input  wire logic                 clock_failed,
  input  wire logic                 interrupt_event,
  input  wire logic                 sleep_mode,
  output logic                      primary_osc_en,
  output logic                      secondary_osc_en,
  output logic                      fast_rc_en,
  output logic                      slow_rc_en,
  output logic                      pll_en,
  output oscsw_pkg::oscsw_src_t     current_source,
  output logic [7:0]                periph_ratio_log2,
  output logic [8:0]                fast_rc_divisor,
  output logic [5:0]                fast_rc_trim_value,
  output logic                      pin_map_freeze
);
  import oscsw_pkg::*;

  oscsw_state_t st_r;
  oscsw_src_t   cur_r;
  oscsw_src_t   next_r;
  logic         freeze_r;
  logic         pinfrz_r;
  logic         lock_r;
  logic         fail_r;
  logic         pkeep_r;
  logic         sec_on_r;
  logic         req_r;
  logic [1:0]   hi_key_r;
  logic [1:0]   lo_key_r;
  logic         wake_r;
  logic [2:0]   ratio_r;
  logic         ratio_en_r;
  logic [2:0]   post_r;
  logic [5:0]   trim_r;
  logic [15:0]  wait_r;
  logic         init_r;

  logic sw_enabled;
  logic fsm_enabled;
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic hi_ok;
  logic lo_ok;
  logic need_pll;
  logic need_xtal;
  logic src_ready;

  assign sw_enabled  = (switch_monitor_cfg[1] == 1'b0); // [RULE_13]
  assign fsm_enabled = (switch_monitor_cfg == 2'b00);
  assign wr      = psel && penable && pwrite && pready;
  assign rd      = psel && !penable && !pwrite;
  assign wr_ctrl = wr && (paddr == `OSCSW_OFF_CTRL);
  // A key is checked per byte lane; a keyed write must be the very next one.
  assign hi_ok = wr_ctrl && pstrb[1] && (hi_key_r == 2'b10); // [RULE_15]
  assign lo_ok = wr_ctrl && pstrb[0] && (lo_key_r == 2'b10); // [RULE_16]
  assign need_pll  = (next_r == SRC_FAST_PLL) || (next_r == SRC_PRI_PLL);
  assign need_xtal = (next_r == SRC_PRI) || (next_r == SRC_PRI_PLL);
  assign src_ready = (need_pll ? lock_r : 1'b1) &&
                     (need_xtal ? (wait_r == 16'h0000) : 1'b1); // [RULE_19]

  always_ff @(posedge ref_clk)
  begin
    pready  <= 1'b0;
    pslverr <= 1'b0;
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= !(paddr == `OSCSW_OFF_CTRL || paddr == `OSCSW_OFF_DIV ||
                   paddr == `OSCSW_OFF_TRIM || paddr == `OSCSW_OFF_STATUS);
      if (rd)
      begin
        case (paddr)
          `OSCSW_OFF_CTRL:   prdata <= {16'h0000, 1'b0, cur_r, 1'b0, next_r,
                                freeze_r, pinfrz_r, lock_r, 1'b0, fail_r,
                                pkeep_r, sec_on_r, req_r};
          `OSCSW_OFF_DIV:    prdata <= {16'h0000, wake_r, ratio_r,
                                        ratio_en_r, post_r, 8'h00};
          `OSCSW_OFF_TRIM:   prdata <= {26'h0000000, trim_r};
          `OSCSW_OFF_STATUS: prdata <= {28'h0000000, st_r, sw_enabled,
                                        fsm_enabled};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Key trackers: 00 none, 01 first key seen, 10 armed for one write.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hi_key_r <= 2'b00;
      lo_key_r <= 2'b00;
    end
    else if (wr_ctrl)
    begin
      if (pstrb[1] && hi_key_r == 2'b00 && pwdata[15:8] == `OSCSW_KEY_HI_A)
        hi_key_r <= 2'b01;
      else if (pstrb[1] && hi_key_r == 2'b01 &&
               pwdata[15:8] == `OSCSW_KEY_HI_B)
        hi_key_r <= 2'b10;
      else
        hi_key_r <= 2'b00;
      if (pstrb[0] && lo_key_r == 2'b00 && pwdata[7:0] == `OSCSW_KEY_LO_A)
        lo_key_r <= 2'b01;
      else if (pstrb[0] && lo_key_r == 2'b01 &&
               pwdata[7:0] == `OSCSW_KEY_LO_B)
        lo_key_r <= 2'b10;
      else
        lo_key_r <= 2'b00;
    end
    else if (wr)
    begin
      hi_key_r <= 2'b00;
      lo_key_r <= 2'b00;
    end
  end

  // Control bits; writes outside a keyed slot change nothing.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      freeze_r <= 1'b0;
      pinfrz_r <= 1'b0;
      pkeep_r  <= 1'b0;
      sec_on_r <= 1'b0;
      next_r   <= SRC_FAST_DIV;
    end
    else
    begin
      if (hi_ok && sw_enabled && !(freeze_r && fsm_enabled)) // [RULE_01]
        next_r <= oscsw_src_t'(pwdata[10:8]); // [RULE_24]
      if (lo_ok) // [RULE_24]
      begin
        if (pwdata[`OSCSW_BIT_FREEZE])
          freeze_r <= 1'b1;
        if (!(pin_lock_one_shot && pinfrz_r)) // [RULE_02]
          pinfrz_r <= pwdata[`OSCSW_BIT_PINFRZ];
        pkeep_r <= pwdata[`OSCSW_BIT_PKEEP]; // [RULE_05]
        sec_on_r <= pwdata[`OSCSW_BIT_SECON]; // [RULE_06]
      end
    end
  end

  // Sequencer, current source, request, lock and fail flags.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r   <= SW_IDLE;
      cur_r  <= SRC_FAST_DIV;
      req_r  <= 1'b0;
      lock_r <= 1'b0;
      fail_r <= 1'b0;
      wait_r <= 16'h0000;
      init_r <= 1'b1;
    end
    else
    begin
      init_r <= 1'b0;
      if (init_r || !sw_enabled)
        cur_r <= poweron_source_cfg; // [RULE_14]
      // The fail flag is written clear-only; a new failure wins the clear.
      if (fsm_enabled && clock_failed)
        fail_r <= 1'b1; // [RULE_04]
      else if (lo_ok && !pwdata[`OSCSW_BIT_FAIL])
        fail_r <= 1'b0;
      lock_r <= pll_locked && pll_en; // [RULE_03]
      if (wait_r != 16'h0000)
        wait_r <= wait_r - 16'h0001;
      case (st_r)
        SW_IDLE:
        begin
          if (lo_ok && pwdata[`OSCSW_BIT_REQ] && sw_enabled &&
              !(freeze_r && fsm_enabled)) // [RULE_01] [RULE_07]
          begin
            req_r <= 1'b1;
            st_r  <= SW_CHECK;
          end
          else
            req_r <= 1'b0; // [RULE_14]
        end
        SW_CHECK:
        begin
          if (cur_r == next_r) // [RULE_17]
          begin
            req_r <= 1'b0;
            st_r  <= SW_IDLE;
          end
          else
          begin
            lock_r <= 1'b0; // [RULE_18]
            fail_r <= 1'b0;
            wait_r <= need_xtal ? STARTUP_CYCLES : 16'h0000;
            st_r   <= SW_START;
          end
        end
        SW_START:
        begin
          if (src_ready) // [RULE_19]
          begin
            wait_r <= {12'h000, `OSCSW_SETTLE_CYC};
            st_r   <= SW_SETTLE;
          end
        end
        SW_SETTLE:
        begin
          if (wait_r == 16'h0001) // [RULE_20]
          begin
            cur_r  <= next_r;
            req_r  <= 1'b0;
            lock_r <= 1'b0;
            st_r   <= SW_IDLE;
          end
        end
        default: st_r <= SW_IDLE;
      endcase
    end
  end

  // Divider and trim registers.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wake_r     <= 1'b0;
      ratio_r    <= 3'h0;
      ratio_en_r <= 1'b0;
      post_r     <= 3'(`OSCSW_DIV_RESET >> 8); // [RULE_11]
      trim_r     <= 6'h00;
    end
    else
    begin
      if (wr && paddr == `OSCSW_OFF_DIV && pstrb[1])
      begin
        wake_r     <= pwdata[15];
        ratio_r    <= pwdata[14:12];
        ratio_en_r <= pwdata[11];
        post_r     <= pwdata[10:8];
      end
      if (wake_r && interrupt_event)
        ratio_en_r <= 1'b0; // [RULE_08]
      if (wr && paddr == `OSCSW_OFF_TRIM && pstrb[0])
        trim_r <= pwdata[5:0]; // [RULE_12]
    end
  end

  // Oscillator enables; an old source other than a kept slow RC or secondary drops once current moves on.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      primary_osc_en    <= 1'b0;
      secondary_osc_en  <= 1'b0;
      fast_rc_en        <= 1'b1;
      slow_rc_en        <= 1'b0;
      pll_en            <= 1'b0;
      current_source    <= SRC_FAST_DIV;
      periph_ratio_log2 <= 8'h00;
      fast_rc_divisor   <= 9'h002;
      fast_rc_trim_value <= 6'h00;
      pin_map_freeze    <= 1'b0;
    end
    else
    begin
      // [RULE_21] [RULE_23]
      primary_osc_en <= ((cur_r == SRC_PRI || cur_r == SRC_PRI_PLL) &&
                         !(sleep_mode && !pkeep_r)) ||
                        (st_r != SW_IDLE && need_xtal); // [RULE_05]
      secondary_osc_en <= sec_on_r || cur_r == SRC_SEC ||
                          (st_r != SW_IDLE && next_r == SRC_SEC); // [RULE_06]
      fast_rc_en <= cur_r == SRC_FAST || cur_r == SRC_FAST_PLL ||
                    cur_r == SRC_FAST_DIV ||
                    (st_r != SW_IDLE && (next_r == SRC_FAST ||
                     next_r == SRC_FAST_PLL || next_r == SRC_FAST_DIV));
      // The watchdog and the monitor run on the slow RC, so either keeps it up.
      slow_rc_en <= wdt_enabled || fsm_enabled || cur_r == SRC_SLOW_RC ||
                    (st_r != SW_IDLE && next_r == SRC_SLOW_RC); // [RULE_21]
      pll_en <= cur_r == SRC_FAST_PLL || cur_r == SRC_PRI_PLL ||
                (st_r != SW_IDLE && need_pll); // [RULE_03]
      current_source <= cur_r;
      periph_ratio_log2 <= ratio_en_r ? {5'h00, ratio_r} : 8'h00;
      // [RULE_09] [RULE_10]
      fast_rc_divisor <= (post_r == 3'h7) ? 9'h100 :
                         (9'h001 << post_r); // [RULE_11]
      fast_rc_trim_value <= trim_r;
      pin_map_freeze <= pinfrz_r;
    end
  end

  settle_count_a: assert property (@(posedge ref_clk) // [RULE_20]
    disable iff (!rst_n)
    st_r == SW_SETTLE && $past(st_r) == SW_START |-> ##10 cur_r == next_r)
    else $error("switch not done ten cycles after ready");
  redundant_a: assert property (@(posedge ref_clk) // [RULE_17]
    disable iff (!rst_n)
    st_r == SW_CHECK && cur_r == next_r |=> !req_r && st_r == SW_IDLE)
    else $error("redundant switch not aborted");
  clear_flags_a: assert property (@(posedge ref_clk) // [RULE_18]
    disable iff (!rst_n)
    st_r == SW_CHECK && cur_r != next_r |=> !lock_r && !fail_r)
    else $error("valid switch kept lock or fail");
  req_held_a: assert property (@(posedge ref_clk) // [RULE_14]
    disable iff (!rst_n)
    !sw_enabled |=> !req_r)
    else $error("request set while switching disabled");
  oneshot_a: assert property (@(posedge ref_clk) // [RULE_02]
    disable iff (!rst_n)
    pin_lock_one_shot && pinfrz_r |=> pinfrz_r)
    else $error("one-shot pin freeze cleared");
  unkeyed_a: assert property (@(posedge ref_clk) // [RULE_24]
    disable iff (!rst_n)
    wr_ctrl && lo_key_r != 2'b10 |=> $stable(sec_on_r) && $stable(pkeep_r))
    else $error("unkeyed low byte write took effect");
  wake_a: assert property (@(posedge ref_clk) // [RULE_08]
    disable iff (!rst_n)
    wake_r && interrupt_event |=> !ratio_en_r ##1 periph_ratio_log2 == 8'h00)
    else $error("interrupt did not restore ratio");
  fail_set_a: assert property (@(posedge ref_clk) // [RULE_04]
    disable iff (!rst_n)
    fsm_enabled && clock_failed |=> fail_r)
    else $error("clock failure not flagged");
  ratio_off_a: assert property (@(posedge ref_clk) // [RULE_10]
    disable iff (!rst_n)
    !ratio_en_r |=> periph_ratio_log2 == 8'h00)
    else $error("ratio applied while disabled");
  slow_rc_keep_a: assert property (@(posedge ref_clk) // [RULE_21]
    disable iff (!rst_n)
    wdt_enabled || fsm_enabled |=> slow_rc_en)
    else $error("slow RC dropped while still needed");
endmodule : oscsw_ctrl

//--- tb/oscsw_ctrl_test.sv
// Self-checking testbench for the oscillator switch control block.
`timescale 1ns/10ps
`include "oscsw_consts.svh"
module oscsw_ctrl_test;
  import oscsw_pkg::*;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic [7:0]  rat;
    logic [8:0]  dv;
    logic [5:0]  tr;
  } oscsw_row_t;
  // A short start-up count keeps the primary switch quick in simulation.
  localparam logic [15:0] STARTUP = 16'h0010;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  mon_cfg;
  oscsw_src_t  pon_src, cur;
  logic        one_shot, pll_locked, clock_failed, irq, sleep_mode, perr;
  logic        pri_en, sec_en, fast_en, slow_en, pll_en, pin_frz;
  logic [7:0]  ratio, lowb;
  logic [8:0]  div;
  logic [5:0]  trim;
  int          err_count, cmp_count, cnt;
  oscsw_row_t  rows [0:11] = '{
    '{12'h004, 32'h0800, 32'h0800, 8'h00, 9'h001, 6'h00},
    '{12'h004, 32'h1900, 32'h1900, 8'h01, 9'h002, 6'h00},
    '{12'h004, 32'h2A00, 32'h2A00, 8'h02, 9'h004, 6'h00},
    '{12'h004, 32'h3B00, 32'h3B00, 8'h03, 9'h008, 6'h00},
    '{12'h004, 32'h4C00, 32'h4C00, 8'h04, 9'h010, 6'h00},
    '{12'h004, 32'h5D00, 32'h5D00, 8'h05, 9'h020, 6'h00},
    '{12'h004, 32'h6E00, 32'h6E00, 8'h06, 9'h040, 6'h00},
    '{12'h004, 32'h7F00, 32'h7F00, 8'h07, 9'h100, 6'h00},
    '{12'h004, 32'hFFFFFFFF, 32'hFF00, 8'h07, 9'h100, 6'h00},
    '{12'h004, 32'h7700, 32'h7700, 8'h00, 9'h100, 6'h00},
    '{12'h008, 32'h001F, 32'h001F, 8'h00, 9'h100, 6'h1F},
    '{12'h008, 32'hFFFFFFFF, 32'h003F, 8'h00, 9'h100, 6'h3F}
  };

  oscsw_ctrl #(.STARTUP_CYCLES(STARTUP)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .switch_monitor_cfg(mon_cfg), .poweron_source_cfg(pon_src),
    .pin_lock_one_shot(one_shot), .wdt_enabled(1'b0),
    .pll_locked(pll_locked), .clock_failed(clock_failed),
    .interrupt_event(irq), .sleep_mode(sleep_mode),
    .primary_osc_en(pri_en), .secondary_osc_en(sec_en),
    .fast_rc_en(fast_en), .slow_rc_en(slow_en), .pll_en(pll_en),
    .current_source(cur), .periph_ratio_log2(ratio),
    .fast_rc_divisor(div), .fast_rc_trim_value(trim),
    .pin_map_freeze(pin_frz)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // The request is held until pready is sampled high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      chk("apb handshake", 32'h0, 32'h1);
      close_out();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic key(input logic hi, input logic [7:0] b);
    logic [3:0] s;
    s = hi ? 4'h2 : 4'h1;
    apb(1'b1, `OSCSW_OFF_CTRL, hi ? {16'h0000, `OSCSW_KEY_HI_A, 8'h00}
        : {24'h000000, `OSCSW_KEY_LO_A}, s);
    apb(1'b1, `OSCSW_OFF_CTRL, hi ? {16'h0000, `OSCSW_KEY_HI_B, 8'h00}
        : {24'h000000, `OSCSW_KEY_LO_B}, s);
    apb(1'b1, `OSCSW_OFF_CTRL, hi ? {16'h0000, b, 8'h00} : {24'h000000, b}, s);
  endtask : key

  task automatic sw(input oscsw_src_t src, input logic [7:0] extra);
    key(1'b1, {5'h00, src});
    key(1'b0, lowb | extra | 8'h01);
  endtask : sw

  task automatic wsrc(input oscsw_src_t src, input int max);
    cnt = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end while (cur !== src && cnt < max);
    if (cur !== src)
    begin
      chk("switch wait", 32'(cur), 32'(src));
      close_out();
    end
  endtask : wsrc

  task automatic pulse_irq;
    @(posedge ref_clk);
    irq <= 1'b1;
    @(posedge ref_clk);
    irq <= 1'b0;
    tick(1);
  endtask : pulse_irq

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {pll_locked, clock_failed, irq, sleep_mode, err_count, cmp_count} = '0;
    mon_cfg = 2'b00;
    pon_src = SRC_FAST;
    one_shot = 1'b1;
    lowb = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // The source register loads first and the output follows one edge later.
    tick(2);
    chk("source", 32'(cur), 32'(SRC_FAST));
    chk("slow rc on", 32'(slow_en), 32'h1);
    apb(1'b0, `OSCSW_OFF_CTRL, 32'h0, 4'h0);
    chk("ctrl reset", rd, 32'h0700);
    apb(1'b0, `OSCSW_OFF_STATUS, 32'h0, 4'h0);
    chk("status on", rd, 32'h3);
    apb(1'b0, `OSCSW_OFF_DIV, 32'h0, 4'h0);
    chk("div reset", rd, 32'h0100);
    chk("divisor reset", 32'(div), 32'h2);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d, 4'hF);
      apb(1'b0, rows[i].a, 32'h0, 4'h0);
      chk("readback", rd, rows[i].r);
      tick(1);
      chk("ratio", 32'(ratio), 32'(rows[i].rat));
      chk("divisor", 32'(div), 32'(rows[i].dv));
      chk("trim", 32'(trim), 32'(rows[i].tr));
    end
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    chk("unmapped error", 32'(perr), 32'h1);
    // Writes with no keys in front must leave the control register alone.
    apb(1'b1, `OSCSW_OFF_CTRL, 32'h0042, 4'h1);
    apb(1'b1, `OSCSW_OFF_CTRL, 32'h0200, 4'h2);
    apb(1'b0, `OSCSW_OFF_CTRL, 32'h0, 4'h0);
    chk("unkeyed ctrl", rd, 32'h0700);
    chk("unkeyed sec", 32'(sec_en), 32'h0);
    key(1'b0, 8'h46);
    tick(1);
    chk("sec on", 32'(sec_en), 32'h1);
    chk("pin freeze set", 32'(pin_frz), 32'h1);
    lowb = 8'h04;
    key(1'b0, lowb);
    tick(1);
    chk("sec off", 32'(sec_en), 32'h0);
    chk("pin freeze sticks", 32'(pin_frz), 32'h1);
    sw(SRC_FAST, 8'h00);
    tick(3);
    apb(1'b0, `OSCSW_OFF_CTRL, 32'h0, 4'h0);
    chk("redundant", rd, 32'h0044);
    sw(SRC_PRI, 8'h00);
    wsrc(SRC_PRI, 300);
    chk("primary delay", 32'(cnt >= STARTUP + 10), 32'h1);
    apb(1'b0, `OSCSW_OFF_CTRL, 32'h0, 4'h0);
    chk("primary ctrl", rd, 32'h2244);
    chk("primary on", 32'(pri_en), 32'h1);
    chk("old rc off", 32'(fast_en), 32'h0);
    @(posedge ref_clk);
    sleep_mode <= 1'b1;
    tick(2);
    chk("sleep keep", 32'(pri_en), 32'h1);
    lowb = 8'h00;
    key(1'b0, lowb);
    tick(2);
    chk("sleep stop", 32'(pri_en), 32'h0);
    @(posedge ref_clk);
    sleep_mode <= 1'b0;
    sw(SRC_PRI_PLL, 8'h00);
    tick(60);
    chk("pll wait", 32'(cur), 32'(SRC_PRI));
    chk("pll on", 32'(pll_en), 32'h1);
    @(posedge ref_clk);
    pll_locked <= 1'b1;
    wsrc(SRC_PRI_PLL, 200);
    chk("pll settle", 32'(cnt >= 10), 32'h1);
    @(posedge ref_clk);
    clock_failed <= 1'b1;
    @(posedge ref_clk);
    clock_failed <= 1'b0;
    apb(1'b0, `OSCSW_OFF_CTRL, 32'h0, 4'h0);
    chk("lock and fail", rd, 32'h3368);
    // Writing one to the clear-only fail bit leaves only the switch to clear it.
    sw(SRC_FAST, 8'h08);
    wsrc(SRC_FAST, 200);
    apb(1'b0, `OSCSW_OFF_CTRL, 32'h0, 4'h0);
    chk("switch clears", rd, 32'h0040);
    chk("old pll off", 32'(pll_en), 32'h0);
    apb(1'b1, `OSCSW_OFF_DIV, 32'hBB00, 4'hF);
    tick(1);
    chk("ratio on", 32'(ratio), 32'h3);
    pulse_irq();
    chk("irq restore", 32'(ratio), 32'h0);
    apb(1'b0, `OSCSW_OFF_DIV, 32'h0, 4'h0);
    chk("irq div", rd, 32'hB300);
    apb(1'b1, `OSCSW_OFF_DIV, 32'h3B00, 4'hF);
    pulse_irq();
    chk("irq ignored", 32'(ratio), 32'h3);
    key(1'b0, 8'h80);
    sw(SRC_PRI, 8'h00);
    tick(80);
    chk("frozen", 32'(cur), 32'(SRC_FAST));
    @(posedge ref_clk);
    rst_n <= 1'b0;
    mon_cfg <= 2'b10;
    pon_src <= SRC_SLOW_RC;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(2);
    chk("poweron source", 32'(cur), 32'(SRC_SLOW_RC));
    apb(1'b0, `OSCSW_OFF_STATUS, 32'h0, 4'h0);
    chk("status off", rd, 32'h0);
    sw(SRC_FAST, 8'h00);
    tick(40);
    chk("no switching", 32'(cur), 32'(SRC_SLOW_RC));
    apb(1'b0, `OSCSW_OFF_CTRL, 32'h0, 4'h0);
    chk("request held", 32'(rd[0]), 32'h0);
    chk("current field", 32'(rd[14:12]), 32'h5);
    close_out();
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    chk("run time", 32'h0, 32'h1);
    close_out();
  end
endmodule : oscsw_ctrl_test
